// >>> hdl/amg_map.svh
`ifndef AMG_MAP_SVH
`define AMG_MAP_SVH

// Reset value of the protect state (permissive)
`define AMG_PROT_RST     1'b0
// Default region bounds (byte addresses, 16-bit space)
`define AMG_RAM_BASE     16'h0000
`define AMG_RAM_LIMIT    16'h0fff
`define AMG_OSSTK_BASE   16'h0000
`define AMG_OSSTK_LIMIT  16'h00ff
`define AMG_OSWRK_BASE   16'h0100
`define AMG_OSWRK_LIMIT  16'h01ff
`define AMG_CPRAM_BASE   16'h0e00
`define AMG_CPRAM_LIMIT  16'h0fff
`define AMG_APP_BASE     16'h8000
`define AMG_APP_LIMIT    16'hbfff
`define AMG_CALL_BASE    16'hf000
`define AMG_CALL_LIMIT   16'hf0ff
`define AMG_RET_BASE     16'hf100
`define AMG_RET_LIMIT    16'hf1ff
`define AMG_IRQ_BASE     16'hf200
`define AMG_IRQ_LIMIT    16'hf2ff
// Index of the system control register among general purpose registers
`define AMG_SYSREG_IDX   4'h0

`endif

// >>> hdl/amg_pkg.sv
package amg_pkg;
  typedef enum logic [1:0] {
    AMG_XFER_NONE = 2'b00,
    AMG_XFER_CALL = 2'b01,
    AMG_XFER_RET  = 2'b10,
    AMG_XFER_IRQ  = 2'b11
  } amg_xfer_e;
  typedef logic [15:0] amg_addr_t;
endpackage : amg_pkg

// >>> hdl/amg_range.sv
`timescale 1ns/1ps
module amg_range #(
  parameter int AW = 16
) (
  // Address under test and bounds
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [AW-1:0] base_i,
  input  wire logic [AW-1:0] limit_i,
  // Result
  output logic               hit_o
);
  assign hit_o = (addr_i >= base_i) && (addr_i <= limit_i);
endmodule : amg_range

// >>> hdl/amg_guard.sv
// Function
// - With protection on, RAM access passes outside reserved regions.
// - With protection on, the OS stack region of RAM is blocked.
// - With protection on, the OS working region of RAM is blocked.
// - With protection on, shared coprocessor RAM needs its enable.
// - With protection on, other memory is refused save the exceptions.
// - With protection on, application memory is read-only.
// - With protection on, every register but the system one is open.
// - A turn-on request is honoured only from unprotected code.
// - A protected call into the call entry region turns protection off.
// - A protected return into its entry region turns protection off.
// - Interrupt entry turns protection off; calls, returns and reset can clear it too.
// - With protection off, every access is allowed.
// - After reset protection is off until unprotected code enables it.
`timescale 1ns/1ps
`include "amg_map.svh"
module amg_guard
  import amg_pkg::*;
#(
  parameter int AW = 16,
  parameter int DW = 16,
  parameter int RW = 4
) (
  // Clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rst_n_i,
  // CPU memory request
  input  wire logic          mem_req_i,
  input  wire logic          mem_we_i,
  input  wire logic [AW-1:0] mem_addr_i,
  input  wire logic [DW-1:0] mem_wdata_i,
  input  wire logic          reg_req_i,
  input  wire logic          reg_we_i,
  input  wire logic [RW-1:0] reg_idx_i,
  // Read data from memories and registers
  input  wire logic [DW-1:0] mem_rdata_i,
  input  wire logic [DW-1:0] reg_rdata_i,
  // Control flow events
  input  wire logic          prot_on_req_i,
  input  wire logic          protected_call_instruction_i,
  input  wire logic          protected_return_instruction_i,
  input  wire logic          irq_entry_i,
  input  wire logic [AW-1:0] target_addr_i,
  input  wire logic          cpram_en_i,
  // Downstream strobes
  output logic               mem_req_o,
  output logic               mem_we_o,
  output logic [AW-1:0]      mem_addr_o,
  output logic [DW-1:0]      mem_wdata_o,
  output logic               reg_req_o,
  output logic               reg_we_o,
  output logic [RW-1:0]      reg_idx_o,
  // Answer to the CPU
  output logic [DW-1:0]      rdata_o,
  output logic               deny_o,
  output logic               prot_on_o
);

  if (AW != 16) begin : g_bad_aw
    $error("amg_guard: AW must be 16");
  end
  if (RW < 1 || DW < 1) begin : g_bad_width
    $error("amg_guard: bad width");
  end

  typedef struct packed {
    logic          prot;
    logic          deny;
    logic          was_read;
    logic          reg_side;
    logic          req;
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          rreq;
    logic          rwe;
    logic [RW-1:0] ridx;
  } amg_state_s;

  amg_state_s st_r;
  amg_state_s st_nxt;
  logic       rst_s1_r;
  logic       rst_s2_r;
  logic       rst_n;

  // Reset release through two flops
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  logic hit_ram;
  logic hit_stk;
  logic hit_wrk;
  logic hit_cp;
  logic hit_app;
  logic hit_call;
  logic hit_ret;
  logic hit_irq;

  amg_range #(.AW(AW)) u_ram (
    .addr_i (mem_addr_i),
    .base_i (`AMG_RAM_BASE),
    .limit_i(`AMG_RAM_LIMIT),
    .hit_o  (hit_ram)
  );
  amg_range #(.AW(AW)) u_stk (
    .addr_i (mem_addr_i),
    .base_i (`AMG_OSSTK_BASE),
    .limit_i(`AMG_OSSTK_LIMIT),
    .hit_o  (hit_stk)
  );
  amg_range #(.AW(AW)) u_wrk (
    .addr_i (mem_addr_i),
    .base_i (`AMG_OSWRK_BASE),
    .limit_i(`AMG_OSWRK_LIMIT),
    .hit_o  (hit_wrk)
  );
  amg_range #(.AW(AW)) u_cp (
    .addr_i (mem_addr_i),
    .base_i (`AMG_CPRAM_BASE),
    .limit_i(`AMG_CPRAM_LIMIT),
    .hit_o  (hit_cp)
  );
  amg_range #(.AW(AW)) u_app (
    .addr_i (mem_addr_i),
    .base_i (`AMG_APP_BASE),
    .limit_i(`AMG_APP_LIMIT),
    .hit_o  (hit_app)
  );
  amg_range #(.AW(AW)) u_call (
    .addr_i (target_addr_i),
    .base_i (`AMG_CALL_BASE),
    .limit_i(`AMG_CALL_LIMIT),
    .hit_o  (hit_call)
  );
  amg_range #(.AW(AW)) u_ret (
    .addr_i (target_addr_i),
    .base_i (`AMG_RET_BASE),
    .limit_i(`AMG_RET_LIMIT),
    .hit_o  (hit_ret)
  );
  amg_range #(.AW(AW)) u_irq (
    .addr_i (target_addr_i),
    .base_i (`AMG_IRQ_BASE),
    .limit_i(`AMG_IRQ_LIMIT),
    .hit_o  (hit_irq)
  );

  logic      mem_ok;
  logic      reg_ok;
  logic      call_off;
  logic      ret_off;
  amg_xfer_e xfer;

  always_comb begin
    mem_ok = 1'b0;
    if (!st_r.prot) begin
      mem_ok = 1'b1;
    end else if (hit_ram) begin
      mem_ok = !hit_stk && !hit_wrk
               && (!hit_cp || cpram_en_i);
    end else if (hit_app) begin
      mem_ok = !mem_we_i;
    end else begin
      mem_ok = 1'b0;
    end
    reg_ok = !st_r.prot
             || (reg_idx_i != RW'(`AMG_SYSREG_IDX));
  end

  assign call_off = protected_call_instruction_i && hit_call;
  assign ret_off  = protected_return_instruction_i && hit_ret;

  always_comb begin
    if (irq_entry_i) xfer = AMG_XFER_IRQ;
    else if (call_off) xfer = AMG_XFER_CALL;
    else if (ret_off) xfer = AMG_XFER_RET;
    else xfer = AMG_XFER_NONE;
  end

  always_comb begin
    st_nxt = st_r;
    unique case (xfer)
      AMG_XFER_IRQ,
      AMG_XFER_CALL,
      AMG_XFER_RET: st_nxt.prot = 1'b0;
      AMG_XFER_NONE: begin
        if (prot_on_req_i && !st_r.prot) begin
          st_nxt.prot = 1'b1;
        end
      end
    endcase
    // Requests pass one cycle late, gated by the check
    st_nxt.req      = mem_req_i && mem_ok;
    st_nxt.we       = mem_req_i && mem_we_i && mem_ok;
    st_nxt.addr     = mem_addr_i;
    st_nxt.wdata    = mem_wdata_i;
    st_nxt.rreq     = reg_req_i && reg_ok;
    st_nxt.rwe      = reg_req_i && reg_we_i && reg_ok;
    st_nxt.ridx     = reg_idx_i;
    st_nxt.deny     = (mem_req_i && !mem_ok) || (reg_req_i && !reg_ok);
    st_nxt.reg_side = reg_req_i;
    st_nxt.was_read = (mem_req_i && !mem_we_i && mem_ok)
                      || (reg_req_i && !reg_we_i && reg_ok);
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= '0;
      st_r.prot <= `AMG_PROT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mem_req_o   = st_r.req;
  assign mem_we_o    = st_r.we;
  assign mem_addr_o  = st_r.addr;
  assign mem_wdata_o = st_r.wdata;
  assign reg_req_o   = st_r.rreq;
  assign reg_we_o    = st_r.rwe;
  assign reg_idx_o   = st_r.ridx;
  assign deny_o      = st_r.deny;
  assign prot_on_o   = st_r.prot;
  // Denied or idle cycles read as zero
  assign rdata_o = !st_r.was_read ? '0 :
                   (st_r.reg_side ? reg_rdata_i : mem_rdata_i);

  a_stack_block: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    st_r.prot && mem_req_i && hit_stk |=> !mem_req_o && deny_o)
    else $error("OS stack access passed");
  a_work_block: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    st_r.prot && mem_req_i && hit_wrk |=> !mem_req_o)
    else $error("OS work access passed");
  a_cpram_gate: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    st_r.prot && mem_req_i && hit_cp && !cpram_en_i |=> !mem_req_o)
    else $error("Shared RAM passed while disabled");
  a_ram_open: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    mem_req_i && hit_ram && !hit_stk && !hit_wrk && !hit_cp |=> mem_req_o)
    else $error("Plain RAM access blocked");
  a_app_readonly: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    st_r.prot && mem_req_i && hit_app |=> (mem_req_o != $past(mem_we_i)))
    else $error("Application area policy broken");
  a_other_denied: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    st_r.prot && mem_req_i && !hit_ram && !hit_app |=> !mem_req_o)
    else $error("Non-RAM access passed");
  a_sysreg_shut: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    st_r.prot && reg_req_i |=> reg_req_o == ($past(reg_idx_i) != '0))
    else $error("Register policy broken");
  a_off_open: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    !st_r.prot && (mem_req_i || reg_req_i) |=> !deny_o)
    else $error("Access denied while unprotected");
  a_on_only_off: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    !prot_on_o ##1 prot_on_o |-> $past(prot_on_req_i))
    else $error("Protection set without request");
  a_clear_paths: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    prot_on_o ##1 !prot_on_o |-> $past(irq_entry_i || call_off || ret_off))
    else $error("Protection cleared by other path");
  a_call_clears: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    call_off |=> !prot_on_o)
    else $error("Protected call kept protection");
  a_ret_clears: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    ret_off |=> !prot_on_o)
    else $error("Protected return kept protection");
  a_deny_zero: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    deny_o |-> rdata_o == '0 && !mem_we_o && !reg_we_o)
    else $error("Denied access leaked");
  a_reset_off: assert property (
    @(posedge core_clk_i)
    $rose(rst_n) |-> !prot_on_o)
    else $error("Protection on after reset");

  c_prot_on: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(prot_on_o));
  c_call_off: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    prot_on_o && call_off);
  c_irq_off: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    prot_on_o && irq_entry_i);
  c_denied: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    deny_o);
  c_irq_vector: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    prot_on_o && irq_entry_i && hit_irq);

endmodule : amg_guard

// >>> tb/amg_far_model.sv
`timescale 1ns/1ps
module amg_far_model (
  // Clock
  input  wire logic        core_clk_i,
  // Forwarded requests
  input  wire logic        mem_req_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        reg_req_i,
  input  wire logic [3:0]  reg_idx_i,
  // Read data back to the guard
  output logic [15:0]      mem_rdata_o,
  output logic [15:0]      reg_rdata_o
);
  logic [15:0] cnt_r = 16'h0000;
  always_ff @(posedge core_clk_i) begin
    cnt_r <= cnt_r + 16'h0001;
  end
  // Unselected read lines churn so stale data cannot pass for a match
  assign mem_rdata_o = mem_req_i ? (mem_addr_i ^ 16'h5a5a) : ~cnt_r;
  assign reg_rdata_o = reg_req_i ? ({12'h000, reg_idx_i} ^ 16'ha5a5) : cnt_r;
endmodule : amg_far_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "amg_map.svh"
module testbench;
  import amg_pkg::*;
  logic        core_clk_i, rst_n_i, mem_req_i, mem_we_i, reg_req_i;
  logic        reg_we_i, prot_on_req_i, call_i, ret_i, irq_i, cpram_en_i;
  logic [15:0] mem_addr_i, mem_wdata_i, target_addr_i, mem_rdata, reg_rdata;
  logic [3:0]  reg_idx_i, reg_idx_o;
  logic        mem_req_o, mem_we_o, reg_req_o, reg_we_o, deny_o, prot_on_o;
  logic [15:0] mem_addr_o, mem_wdata_o, rdata_o;
  logic [51:0] exp_q[$];
  logic [51:0] got, expv;
  logic        prot_m;
  int          err_total, n_tests;
  logic [15:0] bnd[12] = '{16'h00ff, 16'h0100, 16'h01ff, 16'h0200,
    16'h0dff, 16'h0e00, 16'h0fff, 16'h1000, 16'h7fff, 16'h8000,
    16'hbfff, 16'hc000};

  amg_guard dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .mem_req_i(mem_req_i), .mem_we_i(mem_we_i), .mem_addr_i(mem_addr_i),
    .mem_wdata_i(mem_wdata_i), .reg_req_i(reg_req_i), .reg_we_i(reg_we_i),
    .reg_idx_i(reg_idx_i), .mem_rdata_i(mem_rdata), .reg_rdata_i(reg_rdata),
    .prot_on_req_i(prot_on_req_i), .protected_call_instruction_i(call_i),
    .protected_return_instruction_i(ret_i), .irq_entry_i(irq_i),
    .target_addr_i(target_addr_i), .cpram_en_i(cpram_en_i),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .reg_req_o(reg_req_o), .reg_we_o(reg_we_o),
    .reg_idx_o(reg_idx_o), .rdata_o(rdata_o), .deny_o(deny_o),
    .prot_on_o(prot_on_o));
  amg_far_model far_u (.core_clk_i(core_clk_i), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .reg_req_i(reg_req_o), .reg_idx_i(reg_idx_o),
    .mem_rdata_o(mem_rdata), .reg_rdata_o(reg_rdata));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  function automatic logic allow(input logic p, input logic r,
    input logic we, input logic [15:0] a, input logic ce);
    if (!p) return 1'b1;
    if (r) return a[3:0] != `AMG_SYSREG_IDX;
    if (a <= `AMG_RAM_LIMIT)
      return a > `AMG_OSWRK_LIMIT && (ce || a < `AMG_CPRAM_BASE);
    return !we && a >= `AMG_APP_BASE && a <= `AMG_APP_LIMIT;
  endfunction : allow

  task automatic acc(input logic r, input logic we, input logic [15:0] a,
    input logic [15:0] wd, input logic ce);
    logic        ok;
    logic [15:0] rd;
    @(posedge core_clk_i);
    ok = allow(prot_m, r, we, a, ce);
    rd = r ? ({12'h000, a[3:0]} ^ 16'ha5a5) : (a ^ 16'h5a5a);
    mem_req_i   <= !r;
    reg_req_i   <= r;
    mem_we_i    <= we;
    reg_we_i    <= we;
    mem_addr_i  <= a;
    reg_idx_i   <= a[3:0];
    mem_wdata_i <= wd;
    cpram_en_i  <= ce;
    exp_q.push_back({r & ok, !r & ok, !ok, ok & we,
      ok ? (r ? {12'h000, a[3:0]} : a) : 16'h0000,
      (ok && !r) ? wd : 16'h0000, (ok && !we) ? rd : 16'h0000});
    @(posedge core_clk_i);
    mem_req_i <= 1'b0;
    reg_req_i <= 1'b0;
  endtask : acc

  // Kind bits: turn-on request, call, return, interrupt
  task automatic ev(input logic [3:0] k, input logic [15:0] t);
    @(posedge core_clk_i);
    {prot_on_req_i, call_i, ret_i, irq_i} <= k;
    target_addr_i <= t;
    if (k[0] || (k[2] && t >= `AMG_CALL_BASE && t <= `AMG_CALL_LIMIT) ||
        (k[1] && t >= `AMG_RET_BASE && t <= `AMG_RET_LIMIT))
      prot_m = 1'b0;
    else if (k[3])
      prot_m = 1'b1;
    @(posedge core_clk_i);
    {prot_on_req_i, call_i, ret_i, irq_i} <= 4'h0;
    @(negedge core_clk_i);
    n_tests++;
    if (prot_on_o !== prot_m) begin
      err_total++;
      $display("unexpected %0t protect state %b", $time, prot_on_o);
    end
  endtask : ev

  task results;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  always @(negedge core_clk_i) begin
    if (mem_req_o === 1'b1 || reg_req_o === 1'b1 || deny_o === 1'b1) begin
      got = {reg_req_o, mem_req_o, deny_o, mem_we_o | reg_we_o,
        deny_o ? 16'h0000 : (reg_req_o ? {12'h000, reg_idx_o} : mem_addr_o),
        mem_req_o ? mem_wdata_o : 16'h0000, rdata_o};
      n_tests++;
      if (exp_q.size() == 0) begin
        err_total++;
        $display("unexpected %0t result with nothing pending", $time);
      end else begin
        expv = exp_q.pop_front();
        if (got !== expv) begin
          err_total++;
          $display("unexpected %0t access got %h exp %h", $time, got, expv);
        end
      end
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_total++;
    $display("unexpected %0t run stalled", $time);
    results();
  end

  initial begin
    {rst_n_i, mem_req_i, mem_we_i, reg_req_i, reg_we_i, prot_on_req_i} = 6'h0;
    {call_i, ret_i, irq_i, cpram_en_i, prot_m} = 5'h0;
    {mem_addr_i, mem_wdata_i, target_addr_i, reg_idx_i} = 52'h0;
    err_total = 0;
    n_tests = 0;
    void'($urandom(18701));
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    ev(4'h0, 16'h0000);
    foreach (bnd[i]) acc(1'b0, i[0], bnd[i], 16'h1234, 1'b0);
    acc(1'b1, 1'b1, 16'h0000, 16'h0000, 1'b0);
    ev(4'h8, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      foreach (bnd[i]) acc(1'b0, c[0], bnd[i], bnd[i], c[1]);
      acc(1'b1, c[0], {15'h0, c[1]}, 16'h0000, 1'b0);
    end
    ev(4'h8, 16'h0000);
    ev(4'h4, 16'hefff);
    ev(4'h4, 16'hf000);
    ev(4'h8, 16'h0000);
    ev(4'h2, 16'hf0ff);
    ev(4'h2, 16'hf1ff);
    ev(4'h8, 16'h0000);
    ev(4'h9, 16'h0000);
    ev(4'h8, 16'h0000);
    ev(4'h1, 16'hf200);
    repeat (200) begin
      if ($urandom % 6 == 0)
        ev(4'($urandom), {6'h3c, 10'($urandom)});
      else
        acc(1'($urandom), 1'($urandom), ($urandom % 2) ? 16'($urandom) :
          {4'h0, 12'($urandom)}, 16'($urandom), 1'($urandom));
    end
    for (int i = 0; i < 5 && exp_q.size() > 0; i++) @(negedge core_clk_i);
    if (exp_q.size() > 0) begin
      err_total++;
      $display("unexpected %0t results missing", $time);
    end
    // Second reset with protection on must clear it again
    ev(4'h8, 16'h0000);
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    prot_m = 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    ev(4'h0, 16'h0000);
    results();
  end
endmodule : testbench
